// ---- hw/ccr_control_regs.sv ----
`timescale 1ns/10ps
module ccr_control_regs (
   input wire logic core_clk,
   input wire logic rst_n,
   input ccr_pkg::ccr_bus_req_t busReq,
   output logic [31:0] rdData,
   input ccr_pkg::ccr_instr_t instr,
   input wire logic agenValid,
   input wire logic [31:0] agenOffset,
   output ccr_pkg::ccr_mem_req_t agenOut,
   input wire logic missValid,
   input wire logic [9:0] missIndex,
   output ccr_pkg::ccr_mem_req_t segOut,
   output logic segCacheable,
   output logic noCachePin,
   output logic tlbFlush,
   input wire logic [127:0] eventVec,
   input wire logic vecValid,
   input ccr_pkg::ccr_vec_kind_t vecKind,
   input wire logic vecDone,
   input wire logic vecFault,
   input wire logic memFault,
   output ccr_pkg::ccr_mem_req_t vecOut,
   output logic coreReset
);

   function automatic logic [5:0] vecOffset(input ccr_pkg::ccr_vec_kind_t k);
      logic [5:0] irqNum;
      irqNum = 6'h00;
      case (k)
         ccr_pkg::VK_KERNEL_CALL_INSTR: vecOffset = ccr_pkg::VO_KERNEL_CALL_INSTR;
         ccr_pkg::VK_EXC: vecOffset = ccr_pkg::VO_EXC;
         ccr_pkg::VK_TRAP: vecOffset = ccr_pkg::VO_TRAP;
         ccr_pkg::VK_UNIMP: vecOffset = ccr_pkg::VO_UNIMP;
         ccr_pkg::VK_NMI: vecOffset = ccr_pkg::VO_NMI;
         ccr_pkg::VK_IRQ1, ccr_pkg::VK_IRQ2, ccr_pkg::VK_IRQ3,
         ccr_pkg::VK_IRQ4, ccr_pkg::VK_IRQ5, ccr_pkg::VK_IRQ6: begin
            // Interrupts 1 to 6 sit one word apart above the nonmaskable slot
            irqNum = {2'b00, k} - {2'b00, ccr_pkg::VK_NMI};
            vecOffset = 6'(ccr_pkg::VO_NMI + 6'(irqNum * ccr_pkg::VO_IRQ_STEP));
         end
         ccr_pkg::VK_CNT1: vecOffset = ccr_pkg::VO_CNT1;
         ccr_pkg::VK_CNT2: vecOffset = ccr_pkg::VO_CNT2;
         ccr_pkg::VK_FPE: vecOffset = ccr_pkg::VO_FPE;
         default: vecOffset = ccr_pkg::VO_EXC;
      endcase
   endfunction

   // Pointer registers never hold the reserved low nibble
   function automatic logic [31:0] quadAlign(input logic [31:0] v);
      quadAlign = v & ccr_pkg::QUAD_MASK;
   endfunction

   // Pointer that the stack-select bit makes active
   function automatic logic [31:0] pickSp(input logic sel, input logic [31:0] userSp,
      input logic [31:0] intSp);
      pickSp = sel ? userSp : intSp;
   endfunction

   // Room for one more exception frame on the interrupt stack
   function automatic logic frameFits(input logic [31:0] sp);
      frameFits = sp >= ccr_pkg::FRAME_BYTES;
   endfunction

   // Software-visible registers
   logic [31:0] shadow_ff;
   logic [31:0] nxt_shadow;
   logic [31:0] userSp_ff;
   logic [31:0] nxt_userSp;
   logic [31:0] intSp_ff;
   logic [31:0] nxt_intSp;
   logic [31:0] segBase_ff;
   logic [31:0] nxt_segBase;
   logic [31:0] evtOne_ff;
   logic [31:0] nxt_evtOne;
   logic [31:0] evtTwo_ff;
   logic [31:0] nxt_evtTwo;
   logic [31:0] vecBase_ff;
   logic [31:0] nxt_vecBase;
   logic [31:0] status_ff;
   logic [31:0] nxt_status;
   logic [31:0] setup_ff;
   logic [31:0] nxt_setup;

   // Registered outputs and sequencer state
   logic [31:0] rdData_ff;
   logic [31:0] nxt_rdData;
   ccr_pkg::ccr_mem_req_t agenOut_ff;
   ccr_pkg::ccr_mem_req_t nxt_agenOut;
   ccr_pkg::ccr_mem_req_t segOut_ff;
   ccr_pkg::ccr_mem_req_t nxt_segOut;
   ccr_pkg::ccr_mem_req_t vecOut_ff;
   ccr_pkg::ccr_mem_req_t nxt_vecOut;
   logic segCache_ff;
   logic nxt_segCache;
   logic noCache_ff;
   logic nxt_noCache;
   logic tlbFlush_ff;
   logic nxt_tlbFlush;
   logic coreReset_ff;
   logic nxt_coreReset;
   ccr_pkg::ccr_fetch_state_t state_ff;
   ccr_pkg::ccr_fetch_state_t nxt_state;

   logic stackSel;
   logic virtMode;
   logic [31:0] activeSp;
   logic wrHit;

   always_comb begin
      stackSel = status_ff[ccr_pkg::STACK_SEL_BIT];
      virtMode = status_ff[ccr_pkg::VIRT_BIT];
      activeSp = pickSp(stackSel, userSp_ff, intSp_ff);
      wrHit = busReq.wrStb;
   end

   // Registers written by software or by instruction sequences
   always_comb begin
      logic newSel;
      logic spMoved;
      logic [31:0] wd;
      logic [31:0] newCsp;
      newSel = stackSel;
      spMoved = 1'b0;
      wd = busReq.wrData;
      newCsp = activeSp;
      nxt_shadow = shadow_ff;
      nxt_userSp = userSp_ff;
      nxt_intSp = intSp_ff;
      nxt_segBase = segBase_ff;
      nxt_vecBase = vecBase_ff;
      nxt_status = status_ff;
      nxt_setup = setup_ff;
      nxt_tlbFlush = 1'b0;
      if (wrHit) begin
         case (busReq.addr)
            ccr_pkg::OFS_SHADOW: nxt_shadow = wd & ccr_pkg::QUAD_MASK;
            ccr_pkg::OFS_USER_SP: begin
               nxt_userSp = wd & ccr_pkg::QUAD_MASK;
               spMoved = stackSel;
            end
            ccr_pkg::OFS_INT_SP: begin
               nxt_intSp = wd & ccr_pkg::QUAD_MASK;
               spMoved = !stackSel;
            end
            ccr_pkg::OFS_SEG_BASE: begin
               nxt_segBase = wd & ccr_pkg::SEG_MASK;
               // Only translation state is flushed; the caches keep their lines
               nxt_tlbFlush = 1'b1;
            end
            ccr_pkg::OFS_VEC_BASE: nxt_vecBase = wd & ccr_pkg::QUAD_MASK;
            // A select switch here leaves the shadow alone
            ccr_pkg::OFS_STATUS: nxt_status = wd & ccr_pkg::STATUS_MASK;
            ccr_pkg::OFS_SETUP: nxt_setup = wd & ccr_pkg::SETUP_MASK;
            default: ;
         endcase
      end
      // Instruction sequences override a software write in the same cycle
      if (instr.valid) begin
         case (instr.kind)
            ccr_pkg::IK_KERNEL_CALL_INSTR, ccr_pkg::IK_KERNEL_RETURN_INSTR, ccr_pkg::IK_CONTEXT_RETURN_INSTR: begin
               newSel = instr.newSel;
               nxt_status[ccr_pkg::STACK_SEL_BIT] = newSel;
            end
            default: newSel = stackSel;
         endcase
         if (newSel) begin
            nxt_userSp = instr.newSp & ccr_pkg::QUAD_MASK;
         end else begin
            nxt_intSp = instr.newSp & ccr_pkg::QUAD_MASK;
         end
         spMoved = 1'b1;
      end
      // Each fault re-entry pushes a frame on the interrupt stack
      if (state_ff == ccr_pkg::FS_IDLE && memFault && !vecValid &&
          frameFits(intSp_ff)) begin
         nxt_intSp = intSp_ff - ccr_pkg::FRAME_BYTES;
         spMoved = spMoved || !stackSel;
      end
      // Shadow tracks whichever pointer is active after this cycle
      if (spMoved) begin
         newCsp = pickSp(nxt_status[ccr_pkg::STACK_SEL_BIT], nxt_userSp, nxt_intSp);
         nxt_shadow = quadAlign(newCsp);
      end
      // Self reset clears every software-visible register as the reset pin would, but raises the flush that the pin leaves low
      if (state_ff == ccr_pkg::FS_RESET) begin
         nxt_shadow = ccr_pkg::RST_VALUE;
         nxt_userSp = ccr_pkg::RST_VALUE;
         nxt_intSp = ccr_pkg::RST_VALUE;
         nxt_segBase = ccr_pkg::RST_VALUE;
         nxt_vecBase = ccr_pkg::RST_VALUE;
         nxt_status = ccr_pkg::RST_VALUE;
         nxt_setup = ccr_pkg::RST_VALUE;
         nxt_tlbFlush = 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         shadow_ff <= ccr_pkg::RST_VALUE;
         userSp_ff <= ccr_pkg::RST_VALUE;
         intSp_ff <= ccr_pkg::RST_VALUE;
         segBase_ff <= ccr_pkg::RST_VALUE;
         vecBase_ff <= ccr_pkg::RST_VALUE;
         status_ff <= ccr_pkg::RST_VALUE;
         setup_ff <= ccr_pkg::RST_VALUE;
         tlbFlush_ff <= 1'b0;
      end else begin
         shadow_ff <= nxt_shadow;
         userSp_ff <= nxt_userSp;
         intSp_ff <= nxt_intSp;
         segBase_ff <= nxt_segBase;
         vecBase_ff <= nxt_vecBase;
         status_ff <= nxt_status;
         setup_ff <= nxt_setup;
         tlbFlush_ff <= nxt_tlbFlush;
      end
   end

   // Event counters
   // A software load wins over an event in the same cycle
   always_comb begin
      logic [2:0] selOne;
      logic [6:0] selTwo;
      selOne = setup_ff[ccr_pkg::SEL1_LO +: 3];
      selTwo = setup_ff[ccr_pkg::SEL2_LO +: 7];
      nxt_evtOne = evtOne_ff + {31'h0000_0000, eventVec[selOne]};
      nxt_evtTwo = evtTwo_ff + {31'h0000_0000, eventVec[selTwo]};
      if (wrHit && busReq.addr == ccr_pkg::OFS_EVT_ONE) begin
         nxt_evtOne = busReq.wrData;
      end
      if (wrHit && busReq.addr == ccr_pkg::OFS_EVT_TWO) begin
         nxt_evtTwo = busReq.wrData;
      end
      if (state_ff == ccr_pkg::FS_RESET) begin
         nxt_evtOne = ccr_pkg::RST_VALUE;
         nxt_evtTwo = ccr_pkg::RST_VALUE;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         evtOne_ff <= ccr_pkg::RST_VALUE;
         evtTwo_ff <= ccr_pkg::RST_VALUE;
      end else begin
         evtOne_ff <= nxt_evtOne;
         evtTwo_ff <= nxt_evtTwo;
      end
   end

   // Register read port, data one cycle after the strobe
   always_comb begin
      nxt_rdData = ccr_pkg::RST_VALUE;
      if (busReq.rdStb) begin
         case (busReq.addr)
            ccr_pkg::OFS_SHADOW: nxt_rdData = quadAlign(shadow_ff);
            ccr_pkg::OFS_USER_SP: nxt_rdData = quadAlign(userSp_ff);
            ccr_pkg::OFS_SEG_BASE: nxt_rdData = segBase_ff & ccr_pkg::SEG_MASK;
            ccr_pkg::OFS_EVT_ONE: nxt_rdData = evtOne_ff;
            ccr_pkg::OFS_EVT_TWO: nxt_rdData = evtTwo_ff;
            ccr_pkg::OFS_VEC_BASE: nxt_rdData = vecBase_ff & ccr_pkg::QUAD_MASK;
            ccr_pkg::OFS_STATUS: nxt_rdData = status_ff;
            ccr_pkg::OFS_SETUP: nxt_rdData = setup_ff;
            ccr_pkg::OFS_INT_SP: nxt_rdData = intSp_ff;
            default: nxt_rdData = ccr_pkg::RST_VALUE;
         endcase
      end
   end

   // Read data stand only in the cycle after the strobe
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdData_ff <= ccr_pkg::RST_VALUE;
      end else begin
         rdData_ff <= nxt_rdData;
      end
   end

   // Stack address generation and segment-table miss accesses
   always_comb begin
      nxt_agenOut.valid = agenValid;
      nxt_agenOut.addr = activeSp + agenOffset;
      nxt_agenOut.translate = virtMode;
      nxt_segOut.valid = missValid && virtMode;
      nxt_segOut.addr = {segBase_ff[31:ccr_pkg::PAGE_LO], missIndex, 2'b00};
      nxt_segOut.translate = 1'b0;
      nxt_segCache = segCache_ff;
      nxt_noCache = noCache_ff;
      // Cacheable level holds between misses so the pin stays put
      if (missValid && virtMode) begin
         nxt_segCache = segBase_ff[ccr_pkg::CACHE_BIT];
         nxt_noCache = !segBase_ff[ccr_pkg::CACHE_BIT];
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         agenOut_ff <= '0;
         segOut_ff <= '0;
         segCache_ff <= 1'b0;
         noCache_ff <= 1'b1;
      end else begin
         agenOut_ff <= nxt_agenOut;
         segOut_ff <= nxt_segOut;
         segCache_ff <= nxt_segCache;
         noCache_ff <= nxt_noCache;
      end
   end

   // Vector fetch sequencing and self reset
   always_comb begin
      nxt_state = state_ff;
      nxt_vecOut = '0;
      nxt_coreReset = 1'b0;
      case (state_ff)
         ccr_pkg::FS_IDLE: begin
            if (vecValid) begin
               nxt_vecOut.valid = 1'b1;
               nxt_vecOut.addr = vecBase_ff + {26'h000_0000, vecOffset(vecKind)};
               nxt_vecOut.translate = virtMode;
               nxt_state = ccr_pkg::FS_WAIT;
            end else if (memFault) begin
               // No room for another frame: the core must restart
               if (!frameFits(intSp_ff)) begin
                  nxt_state = ccr_pkg::FS_RESET;
               end else begin
                  nxt_vecOut.valid = 1'b1;
                  nxt_vecOut.addr = vecBase_ff + {26'h000_0000, ccr_pkg::VO_EXC};
                  nxt_vecOut.translate = virtMode;
                  nxt_state = ccr_pkg::FS_WAIT;
               end
            end
         end
         ccr_pkg::FS_WAIT: begin
            if (vecFault) begin
               nxt_state = ccr_pkg::FS_RESET;
            end else if (vecDone) begin
               nxt_state = ccr_pkg::FS_IDLE;
            end
         end
         // One clearing cycle, then the restart pulse to the rest of the core
         ccr_pkg::FS_RESET: begin
            nxt_coreReset = 1'b1;
            nxt_state = ccr_pkg::FS_IDLE;
         end
         default: nxt_state = ccr_pkg::FS_IDLE;
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= ccr_pkg::FS_IDLE;
         vecOut_ff <= '0;
         coreReset_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         vecOut_ff <= nxt_vecOut;
         coreReset_ff <= nxt_coreReset;
      end
   end

   assign rdData = rdData_ff;
   assign agenOut = agenOut_ff;
   assign segOut = segOut_ff;
   assign segCacheable = segCache_ff;
   assign noCachePin = noCache_ff;
   assign tlbFlush = tlbFlush_ff;
   assign vecOut = vecOut_ff;
   assign coreReset = coreReset_ff;

endmodule

// ---- hw/ccr_pkg.sv ----
package ccr_pkg;

   localparam logic [7:0] OFS_SHADOW = 8'h00;
   localparam logic [7:0] OFS_USER_SP = 8'h04;
   localparam logic [7:0] OFS_SEG_BASE = 8'h08;
   localparam logic [7:0] OFS_EVT_ONE = 8'h0c;
   localparam logic [7:0] OFS_EVT_TWO = 8'h10;
   localparam logic [7:0] OFS_VEC_BASE = 8'h14;
   localparam logic [7:0] OFS_STATUS = 8'h18;
   localparam logic [7:0] OFS_SETUP = 8'h1c;
   localparam logic [7:0] OFS_INT_SP = 8'h20;

   localparam logic [31:0] RST_VALUE = 32'h0000_0000;
   localparam logic [31:0] QUAD_MASK = 32'hffff_fff0;
   localparam logic [31:0] SEG_MASK = 32'hffff_f800;
   localparam logic [31:0] STATUS_MASK = 32'h0000_8200;
   localparam logic [31:0] SETUP_MASK = 32'hffc0_0000;
   localparam logic [31:0] FRAME_BYTES = 32'h0000_0010;

   localparam int unsigned STACK_SEL_BIT = 9;
   localparam int unsigned VIRT_BIT = 15;
   localparam int unsigned CACHE_BIT = 11;
   localparam int unsigned PAGE_LO = 12;
   localparam int unsigned SEL1_LO = 22;
   localparam int unsigned SEL2_LO = 25;

   localparam logic [5:0] VO_KERNEL_CALL_INSTR = 6'h00;
   localparam logic [5:0] VO_EXC = 6'h04;
   localparam logic [5:0] VO_TRAP = 6'h08;
   localparam logic [5:0] VO_UNIMP = 6'h0c;
   localparam logic [5:0] VO_NMI = 6'h10;
   localparam logic [5:0] VO_IRQ_STEP = 6'h04;
   localparam logic [5:0] VO_CNT1 = 6'h2c;
   localparam logic [5:0] VO_CNT2 = 6'h30;
   localparam logic [5:0] VO_FPE = 6'h34;

   typedef enum logic [3:0] {
      VK_KERNEL_CALL_INSTR = 4'b0000, VK_EXC = 4'b0001, VK_TRAP = 4'b0010, VK_UNIMP = 4'b0011,
      VK_NMI = 4'b0100, VK_IRQ1 = 4'b0101, VK_IRQ2 = 4'b0110, VK_IRQ3 = 4'b0111,
      VK_IRQ4 = 4'b1000, VK_IRQ5 = 4'b1001, VK_IRQ6 = 4'b1010, VK_CNT1 = 4'b1011,
      VK_CNT2 = 4'b1100, VK_FPE = 4'b1101
   } ccr_vec_kind_t;

   typedef enum logic [2:0] {
      IK_CONTEXT_RETURN_INSTR = 3'b000, IK_ENTER = 3'b001, IK_KERNEL_CALL_INSTR = 3'b010, IK_KERNEL_RETURN_INSTR = 3'b011,
      IK_RET = 3'b100, IK_CALL = 3'b101, IK_POP_FRAME_INSTR = 3'b110
   } ccr_instr_kind_t;

   typedef enum logic [1:0] {
      FS_IDLE = 2'b00, FS_WAIT = 2'b01, FS_RESET = 2'b10
   } ccr_fetch_state_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wrData;
      logic wrStb;
      logic rdStb;
   } ccr_bus_req_t;

   typedef struct packed {
      logic valid;
      ccr_instr_kind_t kind;
      logic [31:0] newSp;
      logic newSel;
   } ccr_instr_t;

   typedef struct packed {
      logic valid;
      logic [31:0] addr;
      logic translate;
   } ccr_mem_req_t;
endpackage

// ---- verification/ccr_control_regs_checker.sv ----
`timescale 1ns/10ps
module ccr_control_regs_checker (
   input wire logic core_clk,
   input wire logic rst_n,
   input ccr_pkg::ccr_bus_req_t busReq,
   input wire logic [31:0] rdData,
   input wire logic agenValid,
   input wire logic [31:0] agenOffset,
   input ccr_pkg::ccr_mem_req_t agenOut,
   input wire logic missValid,
   input wire logic [9:0] missIndex,
   input ccr_pkg::ccr_mem_req_t segOut,
   input wire logic segCacheable,
   input wire logic noCachePin,
   input wire logic tlbFlush,
   input wire logic vecValid,
   input ccr_pkg::ccr_vec_kind_t vecKind,
   input wire logic vecFault,
   input ccr_pkg::ccr_mem_req_t vecOut,
   input wire logic coreReset
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   sequence s_rd_quad;
      $past(busReq.rdStb) && ($past(busReq.addr) inside {8'h00, 8'h04, 8'h14, 8'h20});
   endsequence
   sequence s_fetch_fault;
      vecOut.valid ##1 vecFault;
   endsequence
   AST_NOCACHE: assert property (noCachePin == !segCacheable)
      else $error("no-cache pin not inverse of cacheable");
   AST_SEG_GATE: assert property (segOut.valid |-> $past(missValid))
      else $error("segment access without miss");
   AST_SEG_ADDR: assert property (segOut.valid |->
      segOut.addr[11:0] == {$past(missIndex), 2'b00} && !segOut.translate)
      else $error("segment access address wrong");
   AST_FLUSH: assert property (busReq.wrStb && busReq.addr == 8'h08 |=> tlbFlush)
      else $error("no flush after segment base write");
   AST_RD_QUAD: assert property (s_rd_quad |-> rdData[3:0] == 4'h0)
      else $error("pointer low bits not zero");
   AST_RD_SEG: assert property ($past(busReq.rdStb) && $past(busReq.addr) == 8'h08
      |-> rdData[10:0] == 11'h000) else $error("segment base low bits not zero");
   AST_AGEN: assert property (agenValid |=>
      agenOut.valid && agenOut.addr[3:0] == $past(agenOffset[3:0]))
      else $error("stack address wrong");
   AST_VEC_SLOT: assert property (vecOut.valid && $past(vecValid) |->
      vecOut.addr[3:0] == {$past(vecKind[1:0]), 2'b00}) else $error("vector slot wrong");
   AST_VEC_FAULT: assert property (s_fetch_fault |=> ##1 coreReset)
      else $error("no reset after vector fault");
endmodule
bind ccr_control_regs ccr_control_regs_checker chk (.core_clk, .rst_n, .busReq, .rdData,
   .agenValid, .agenOffset, .agenOut, .missValid, .missIndex, .segOut, .segCacheable,
   .noCachePin, .tlbFlush, .vecValid, .vecKind, .vecFault, .vecOut, .coreReset);

// ---- verification/tb.sv ----
`timescale 1ns/10ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin err_total++; \
   $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end
module tb;
   logic core_clk = 0;
   logic rst_n = 0;
   ccr_pkg::ccr_bus_req_t busReq = '0;
   ccr_pkg::ccr_instr_t instr = '0;
   ccr_pkg::ccr_mem_req_t agenOut, segOut, vecOut;
   ccr_pkg::ccr_vec_kind_t vecKind = ccr_pkg::VK_KERNEL_CALL_INSTR;
   logic [31:0] rdData;
   logic [31:0] agenOffset = '0;
   logic [9:0] missIndex = '0;
   logic [127:0] eventVec = '0;
   logic agenValid = 0, missValid = 0, vecValid = 0, vecDone = 0, vecFault = 0, memFault = 0;
   logic segCacheable, noCachePin, tlbFlush, coreReset;
   int err_total = 0, samples_checked = 0, cycles = 0;
   always #4 core_clk = ~core_clk;
   ccr_control_regs uut (.core_clk, .rst_n, .busReq, .rdData, .instr, .agenValid, .agenOffset,
      .agenOut, .missValid, .missIndex, .segOut, .segCacheable, .noCachePin, .tlbFlush,
      .eventVec, .vecValid, .vecKind, .vecDone, .vecFault, .memFault, .vecOut, .coreReset);
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      busReq <= '{addr: a, wrData: d, wrStb: w, rdStb: !w};
      @(posedge core_clk);
      busReq <= '0;
      #1;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, '0);
      `CHK(rdData, e)
   endtask
   task automatic step(input int k, input logic [31:0] sp, input logic sel);
      @(posedge core_clk);
      instr <= '{valid: 1'b1, kind: ccr_pkg::ccr_instr_kind_t'(k), newSp: sp, newSel: sel};
      @(posedge core_clk);
      instr <= '0;
   endtask
   task automatic agen(input logic [31:0] o, input logic [31:0] e, input logic t);
      @(posedge core_clk);
      agenValid <= 1;
      agenOffset <= o;
      @(posedge core_clk);
      agenValid <= 0;
      #1;
      `CHK(agenOut, {1'b1, e, t})
   endtask
   task automatic miss(input logic [9:0] i, input logic v, input logic [31:0] e);
      @(posedge core_clk);
      missValid <= 1;
      missIndex <= i;
      @(posedge core_clk);
      missValid <= 0;
      #1;
      `CHK(segOut.valid, v)
      if (v) `CHK(segOut.addr, e)
   endtask
   task automatic vec_req(input int k, input logic [31:0] e, input logic t);
      @(posedge core_clk);
      vecValid <= 1;
      vecKind <= ccr_pkg::ccr_vec_kind_t'(k);
      @(posedge core_clk);
      vecValid <= 0;
      #1;
      `CHK(vecOut, {1'b1, e, t})
   endtask
   // Result and fault strobes: 0 memFault, 1 vecDone, 2 vecFault
   task automatic pulse(input int which);
      @(posedge core_clk);
      case (which)
         0: memFault <= 1;
         1: vecDone <= 1;
         default: vecFault <= 1;
      endcase
      @(posedge core_clk);
      memFault <= 0;
      vecDone <= 0;
      vecFault <= 0;
   endtask
   task automatic wait_core_reset;
      int n = 0;
      while (coreReset !== 1'b1 && n < 8) begin
         @(posedge core_clk);
         #1;
         n++;
      end
      `CHK(coreReset, 1'b1)
   endtask
   function automatic logic [7:0] ofs(input int i);
      return (i == 9) ? 8'h40 : 8'(i * 4);
   endfunction
   task automatic test_regs;
      logic [31:0] expv [10] = '{32'hffff_fff0, 32'hffff_fff0, 32'hffff_f800, 32'hffff_ffff,
         32'hffff_ffff, 32'hffff_fff0, 32'h0000_8200, 32'hffc0_0000, 32'hffff_fff0, 32'h0};
      for (int i = 0; i < 10; i++) rd_chk(ofs(i), 32'h0);
      `CHK(noCachePin, 1'b1)
      for (int i = 0; i < 10; i++) bus(1'b1, ofs(i), 32'hffff_ffff);
      for (int i = 0; i < 10; i++) rd_chk(ofs(i), expv[i]);
      $display("test_regs done");
   endtask
   task automatic test_counter;
      bus(1'b1, 8'h1c, {7'h64, 3'h3, 22'h0});
      bus(1'b1, 8'h0c, 32'hffff_fffe);
      bus(1'b1, 8'h10, 32'h0000_0005);
      @(posedge core_clk);
      eventVec <= (128'h1 << 3) | (128'h1 << 4) | (128'h1 << 100);
      repeat (4) @(posedge core_clk);
      eventVec <= '0;
      rd_chk(8'h0c, 32'h0000_0002);
      rd_chk(8'h10, 32'h0000_0009);
      $display("test_counter done");
   endtask
   task automatic test_stack;
      for (int k = 0; k < 7; k++) begin
         step(k, 32'h0000_1000 + 32'(k) * 32'h100, 1'b1);
         rd_chk(8'h00, 32'h0000_1000 + 32'(k) * 32'h100);
      end
      rd_chk(8'h04, 32'h0000_1600);
      rd_chk(8'h18, 32'h0000_8200);
      agen(32'h0000_0008, 32'h0000_1608, 1'b1);
      bus(1'b1, 8'h18, 32'h0);
      rd_chk(8'h00, 32'h0000_1600);
      agen(32'h0000_0008, 32'hffff_fff8, 1'b0);
      step(2, 32'h0000_4000, 1'b0);
      rd_chk(8'h20, 32'h0000_4000);
      rd_chk(8'h00, 32'h0000_4000);
      $display("test_stack done");
   endtask
   task automatic test_seg;
      bus(1'b1, 8'h18, 32'h0000_8000);
      bus(1'b1, 8'h08, 32'habcd_e9ff);
      `CHK(tlbFlush, 1'b1)
      miss(10'h155, 1'b1, {20'habcde, 10'h155, 2'b00});
      `CHK(noCachePin, 1'b0)
      `CHK(segCacheable, 1'b1)
      bus(1'b1, 8'h08, 32'h1234_5000);
      miss(10'h3ff, 1'b1, {20'h12345, 10'h3ff, 2'b00});
      `CHK(noCachePin, 1'b1)
      `CHK(segCacheable, 1'b0)
      bus(1'b1, 8'h18, 32'h0);
      miss(10'h001, 1'b0, 32'h0);
      $display("test_seg done");
   endtask
   task automatic test_vec;
      bus(1'b1, 8'h14, 32'h0001_0007);
      for (int k = 0; k < 14; k++) begin
         vec_req(k, 32'h0001_0000 + 32'(k * 4), 1'b0);
         pulse(1);
      end
      bus(1'b1, 8'h18, 32'h0000_8000);
      vec_req(13, 32'h0001_0034, 1'b1);
      pulse(1);
      bus(1'b1, 8'h18, 32'h0);
      $display("test_vec done");
   endtask
   task automatic test_fault;
      bus(1'b1, 8'h20, 32'h0000_0020);
      rd_chk(8'h00, 32'h0000_0020);
      for (int n = 0; n < 2; n++) begin
         pulse(0);
         #1;
         `CHK(vecOut, {1'b1, 32'h0001_0004, 1'b0})
         pulse(1);
      end
      rd_chk(8'h20, 32'h0);
      rd_chk(8'h00, 32'h0);
      pulse(0);
      wait_core_reset;
      rd_chk(8'h14, 32'h0);
      bus(1'b1, 8'h14, 32'h0002_0000);
      vec_req(4, 32'h0002_0010, 1'b0);
      pulse(2);
      wait_core_reset;
      rd_chk(8'h14, 32'h0);
      $display("test_fault done");
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 5000) begin
         err_total++;
         $display("[FAIL] %0t timeout", $time);
         wrap_up;
      end
   end
   initial begin
      repeat (8) @(posedge core_clk);
      rst_n <= 1;
      test_regs;
      test_counter;
      test_stack;
      test_seg;
      test_vec;
      test_fault;
      wrap_up;
   end
endmodule
